/* hdl/cnm_pkg.sv */
// Purpose: Shared constants and types for the crate network master controller
// Assumes: 125 MHz module clock, 16-bit dataway words
// Notes: Cycle counts follow from the nominal times and the clock rate
package cnm_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned RESTART_TIME_US = 3000;
	localparam int unsigned RESTART_CYCLES = RESTART_TIME_US * CLK_MHZ;
	localparam int unsigned TIMEOUT_TIME_MS = 500;
	localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_TIME_MS * 1000 * CLK_MHZ;
	localparam int TMR_W = 26;
	localparam logic [TMR_W-1:0] TMR_ZERO = 26'h0000000;
	localparam logic [TMR_W-1:0] TMR_ONE = 26'h0000001;

	// ==========================================================
	// Buffer geometry and reset values
	localparam int WORD_W = 16;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 9;
	localparam int FIFO_DEPTH = 256;
	localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 9'h100;
	localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
	localparam logic [ADDR_W-1:0] PTR_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_ONE = 8'h01;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

	// ==========================================================
	// Dataway function codes
	localparam logic [4:0] FN_READ = 5'h00;
	localparam logic [4:0] FN_TEST_LAM = 5'h08;
	localparam logic [4:0] FN_RESET = 5'h09;
	localparam logic [4:0] FN_WRITE = 5'h10;
	localparam logic [4:0] FN_START = 5'h11;
	localparam logic [4:0] FN_LAM_OFF = 5'h18;
	localparam logic [4:0] FN_LAM_ON = 5'h1a;

	// ==========================================================
	// Reply words
	localparam logic [WORD_W-1:0] ERR_NO_DATA = 16'hfffd;
	localparam logic [WORD_W-1:0] ERR_BAD_ID = 16'hfffe;
	localparam logic [WORD_W-1:0] ERR_NO_SLAVE = 16'hffff;
	localparam logic [WORD_W-1:0] HDR_SUCCESS = 16'h0000;
	localparam logic [7:0] HDR_ERR_BYTE = 8'hff;

	// ==========================================================
	// Controller states
	typedef enum logic [5:0] {
		ST_RESTART = 6'h01,
		ST_IDLE = 6'h02,
		ST_TX = 6'h04,
		ST_WAIT = 6'h08,
		ST_RX = 6'h10,
		ST_ERR = 6'h20
	} cnm_state_t;

	// X answer for every implemented function code
	function automatic logic fn_supported(input logic [4:0] fn);
		fn_supported = (fn == FN_READ) || (fn == FN_TEST_LAM) || (fn == FN_RESET) ||
			(fn == FN_WRITE) || (fn == FN_START) || (fn == FN_LAM_OFF) ||
			(fn == FN_LAM_ON);
	endfunction : fn_supported

	// First reply word: zero for success, all ones in upper byte for errors
	function automatic logic header_ok(input logic [WORD_W-1:0] word);
		header_ok = (word == HDR_SUCCESS) || (word[15:8] == HDR_ERR_BYTE);
	endfunction : header_ok

endpackage : cnm_pkg

/* hdl/cnm_word_mem.sv */
// Purpose: 256 x 16 word store with registered read data
// Assumes: One write and one read address per clock
// Notes: Write to the address being read shows up in the next cycle
`timescale 1ns/100ps
module cnm_word_mem (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic we,
	input wire logic [cnm_pkg::ADDR_W-1:0] waddr,
	input wire logic [cnm_pkg::WORD_W-1:0] wdata,
	input wire logic [cnm_pkg::ADDR_W-1:0] raddr,
	output logic [cnm_pkg::WORD_W-1:0] rdata_ff
);
	import cnm_pkg::*;

	logic [WORD_W-1:0] mem_q [FIFO_DEPTH];
	logic [WORD_W-1:0] nxt_rdata;

	// ==========================================================
	// Read path, bypass keeps a freshly written head word visible
	always_comb begin
		nxt_rdata = (we && (waddr == raddr)) ? wdata : mem_q[raddr];
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= WORD_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Storage array has no reset; pointers decide what is valid
	always_ff @(posedge mclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

endmodule : cnm_word_mem

/* hdl/cnm_ctrl.sv */
// Purpose: Command and buffer logic of a dataway module mastering a serial network
// Assumes: Dataway commands arrive as one-cycle strobes at least 2 cycles apart
// Notes: Serial line coding lives in the node; this block feeds and drains it
//
// Overview of operation
// - Function 9, dataway C or Z, or panel button enter restart.
// - Restart clears buffers and LAM, disables LAM, aborts, refuses commands ~3 ms.
// - Function 16 pushes write word into transmit buffer, Q=1 when accepted.
// - Function 16 refused with Q=0 while node busy or transmit buffer full.
// - Function 17 with non-empty transmit buffer starts sending the packet.
// - Function 17 with empty transmit buffer stores empty-buffer error word instead.
// - Function 17 answers Q=1 when accepted, Q=0 when node busy.
// - After sending, wait 500 ms; no reply stores no-slave error word.
// - Reply with bad header flushes receive buffer, then stores bad-identifier word.
// - Reply or error word present enables reading and raises LAM if enabled.
// - Function 0 returns next receive word, Q=1 valid, Q=0 none left.
// - LAM drops once the last receive word has been read.
// - Function 26 enables LAM generation; function 24 or any reset disables.
// - LAM generation is disabled after power-up.
// - Function 8 answers Q=1 when LAM asserted, else Q=0.
// - Every supported function answers X, and Q unless defined otherwise; function 9 answers Q=0.
// - Both buffers are first-in first-out queues of 16-bit words.
// - First reply word zero on success; other slave errors have upper byte ones.
`timescale 1ns/100ps
module cnm_ctrl #(
	parameter int unsigned RESTART_CYC = cnm_pkg::RESTART_CYCLES,
	parameter int unsigned TIMEOUT_CYC = cnm_pkg::TIMEOUT_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cmd_strobe,
	input wire logic [4:0] cmd_func,
	input wire logic [cnm_pkg::WORD_W-1:0] cmd_wdata,
	input wire logic dataway_c,
	input wire logic dataway_z,
	input wire logic panel_reset,
	output logic ans_valid_ff,
	output logic ans_x_ff,
	output logic ans_q_ff,
	output logic [cnm_pkg::WORD_W-1:0] rd_data_ff,
	output logic lam_ff,
	output logic node_active_ff,
	output logic node_tx_valid_ff,
	output logic [cnm_pkg::WORD_W-1:0] node_tx_data_ff,
	input wire logic node_tx_ready,
	input wire logic node_rx_valid,
	input wire logic [cnm_pkg::WORD_W-1:0] node_rx_data,
	input wire logic node_rx_last
);
	import cnm_pkg::*;

	localparam logic [TMR_W-1:0] RESTART_LAST = TMR_W'(RESTART_CYC - 1);
	localparam logic [TMR_W-1:0] TIMEOUT_LAST = TMR_W'(TIMEOUT_CYC - 1);

	// ==========================================================
	// State
	cnm_state_t state_ff, nxt_state;
	logic [TMR_W-1:0] tmr_ff, nxt_tmr;
	logic [ADDR_W-1:0] tx_wp_ff, nxt_tx_wp, tx_rp_ff, nxt_tx_rp;
	logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
	logic [ADDR_W-1:0] rx_wp_ff, nxt_rx_wp, rx_rp_ff, nxt_rx_rp;
	logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
	logic tx_gap_ff, nxt_tx_gap;
	logic hdr_bad_ff, nxt_hdr_bad;
	logic flush_ff, nxt_flush;
	logic [WORD_W-1:0] err_word_ff, nxt_err_word;
	logic rd_en_ff, nxt_rd_en;
	logic lam_en_ff, nxt_lam_en;
	logic nxt_lam, nxt_ans_valid, nxt_ans_x, nxt_ans_q, nxt_node_active, nxt_node_tx_valid;
	logic [WORD_W-1:0] nxt_rd_data, nxt_node_tx_data;

	// Memory ports
	logic tx_we, rx_we;
	logic [ADDR_W-1:0] rx_waddr;
	logic [WORD_W-1:0] rx_wdata, tx_rdata, rx_rdata;
	logic rst_req, idle, bad_now;

	// ==========================================================
	// Word stores for both queues
	cnm_word_mem u_tx_mem (
		.mclk(mclk),
		.arst_n(arst_n),
		.we(tx_we),
		.waddr(tx_wp_ff),
		.wdata(cmd_wdata),
		.raddr(tx_rp_ff),
		.rdata_ff(tx_rdata)
	);

	cnm_word_mem u_rx_mem (
		.mclk(mclk),
		.arst_n(arst_n),
		.we(rx_we),
		.waddr(rx_waddr),
		.wdata(rx_wdata),
		.raddr(rx_rp_ff),
		.rdata_ff(rx_rdata)
	);

	// Any reset source; all of them are sampled levels
	assign rst_req = dataway_c || dataway_z || panel_reset ||
		(cmd_strobe && (cmd_func == FN_RESET));
	assign idle = (state_ff == ST_IDLE);
	assign bad_now = (state_ff == ST_WAIT) ? !header_ok(node_rx_data) : hdr_bad_ff;

	// ==========================================================
	// Next-state logic: node side first, then commands, reset last
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_tx_wp = tx_wp_ff;
		nxt_tx_rp = tx_rp_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_rx_wp = rx_wp_ff;
		nxt_rx_rp = rx_rp_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_tx_gap = tx_gap_ff;
		nxt_hdr_bad = hdr_bad_ff;
		nxt_flush = flush_ff;
		nxt_err_word = err_word_ff;
		nxt_rd_en = rd_en_ff;
		nxt_lam_en = lam_en_ff;
		nxt_lam = lam_ff;
		nxt_ans_valid = 1'b0;
		nxt_ans_x = ans_x_ff;
		nxt_ans_q = ans_q_ff;
		nxt_rd_data = rd_data_ff;
		nxt_node_active = node_active_ff;
		nxt_node_tx_valid = node_tx_valid_ff;
		nxt_node_tx_data = node_tx_data_ff;
		tx_we = 1'b0;
		rx_we = 1'b0;
		rx_waddr = rx_wp_ff;
		rx_wdata = node_rx_data;

		case (state_ff)
			ST_RESTART: begin
				nxt_tmr = tmr_ff + TMR_ONE;
				if (tmr_ff == RESTART_LAST) begin
					nxt_tmr = TMR_ZERO;
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
			end
			ST_TX: begin
				// One gap cycle after each pop lets the read register catch up
				if (node_tx_valid_ff) begin
					if (node_tx_ready) begin
						nxt_node_tx_valid = 1'b0;
						nxt_tx_rp = tx_rp_ff + PTR_ONE;
						nxt_tx_cnt = tx_cnt_ff - CNT_ONE;
						nxt_tx_gap = 1'b1;
					end
				end else if (tx_gap_ff) begin
					nxt_tx_gap = 1'b0;
				end else if (tx_cnt_ff != CNT_ZERO) begin
					nxt_node_tx_valid = 1'b1;
					nxt_node_tx_data = tx_rdata;
				end else begin
					nxt_state = ST_WAIT;
					nxt_tmr = TMR_ZERO;
				end
			end
			ST_WAIT, ST_RX: begin
				if (node_rx_valid) begin
					// Words past a full buffer are dropped
					if (rx_cnt_ff != FIFO_FULL_CNT) begin
						rx_we = 1'b1;
						nxt_rx_wp = rx_wp_ff + PTR_ONE;
						nxt_rx_cnt = rx_cnt_ff + CNT_ONE;
					end
					nxt_hdr_bad = bad_now;
					nxt_state = ST_RX;
					if (node_rx_last) begin
						if (bad_now) begin
							nxt_state = ST_ERR;
							nxt_err_word = ERR_BAD_ID;
							nxt_flush = 1'b1;
						end else begin
							nxt_state = ST_IDLE;
							nxt_rd_en = 1'b1;
							nxt_lam = lam_en_ff;
							nxt_node_active = 1'b0;
						end
					end
				end else if (state_ff == ST_WAIT) begin
					nxt_tmr = tmr_ff + TMR_ONE;
					if (tmr_ff == TIMEOUT_LAST) begin
						nxt_state = ST_ERR;
						nxt_err_word = ERR_NO_SLAVE;
						nxt_flush = 1'b0;
					end
				end
			end
			ST_ERR: begin
				// Flush rewinds the queue so the error word is alone
				rx_we = 1'b1;
				rx_wdata = err_word_ff;
				if (flush_ff) begin
					rx_waddr = PTR_ZERO;
					nxt_rx_rp = PTR_ZERO;
					nxt_rx_wp = PTR_ONE;
					nxt_rx_cnt = CNT_ONE;
				end else begin
					nxt_rx_wp = rx_wp_ff + PTR_ONE;
					nxt_rx_cnt = rx_cnt_ff + CNT_ONE;
				end
				nxt_flush = 1'b0;
				nxt_rd_en = 1'b1;
				nxt_lam = lam_en_ff;
				nxt_node_active = 1'b0;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_RESTART;
				nxt_tmr = TMR_ZERO;
			end
		endcase

		// Dataway command answer, Q stays low unless a branch accepts
		if (cmd_strobe) begin
			nxt_ans_valid = 1'b1;
			nxt_ans_x = fn_supported(cmd_func);
			nxt_ans_q = 1'b0;
			nxt_rd_data = WORD_ZERO;
			if (state_ff != ST_RESTART) begin
				case (cmd_func)
					FN_READ: begin
						if (rd_en_ff && (rx_cnt_ff != CNT_ZERO)) begin
							nxt_ans_q = 1'b1;
							nxt_rd_data = rx_rdata;
							nxt_rx_rp = rx_rp_ff + PTR_ONE;
							nxt_rx_cnt = rx_cnt_ff - CNT_ONE;
							if (rx_cnt_ff == CNT_ONE) begin
								nxt_lam = 1'b0;
								nxt_rd_en = 1'b0;
							end
						end
					end
					FN_TEST_LAM: begin
						nxt_ans_q = lam_ff;
					end
					FN_WRITE: begin
						if (idle && (tx_cnt_ff != FIFO_FULL_CNT)) begin
							tx_we = 1'b1;
							nxt_tx_wp = tx_wp_ff + PTR_ONE;
							nxt_tx_cnt = tx_cnt_ff + CNT_ONE;
							nxt_ans_q = 1'b1;
						end
					end
					FN_START: begin
						if (idle) begin
							// Old reply is discarded so the new one starts clean
							nxt_ans_q = 1'b1;
							nxt_rx_wp = PTR_ZERO;
							nxt_rx_rp = PTR_ZERO;
							nxt_rx_cnt = CNT_ZERO;
							nxt_rd_en = 1'b0;
							nxt_lam = 1'b0;
							nxt_node_active = 1'b1;
							nxt_tx_gap = 1'b0;
							if (tx_cnt_ff != CNT_ZERO) begin
								nxt_state = ST_TX;
							end else begin
								nxt_state = ST_ERR;
								nxt_err_word = ERR_NO_DATA;
								nxt_flush = 1'b0;
							end
						end
					end
					FN_LAM_OFF: begin
						nxt_ans_q = 1'b1;
						nxt_lam_en = 1'b0;
						nxt_lam = 1'b0;
					end
					FN_LAM_ON: begin
						nxt_ans_q = 1'b1;
						nxt_lam_en = 1'b1;
					end
					default: begin
					end
				endcase
			end
		end

		// Reset sources override everything and retrigger the hold time
		if (rst_req) begin
			nxt_state = ST_RESTART;
			nxt_tmr = TMR_ZERO;
			nxt_tx_wp = PTR_ZERO;
			nxt_tx_rp = PTR_ZERO;
			nxt_tx_cnt = CNT_ZERO;
			nxt_rx_wp = PTR_ZERO;
			nxt_rx_rp = PTR_ZERO;
			nxt_rx_cnt = CNT_ZERO;
			nxt_tx_gap = 1'b0;
			nxt_flush = 1'b0;
			nxt_rd_en = 1'b0;
			nxt_lam = 1'b0;
			nxt_lam_en = 1'b0;
			nxt_node_active = 1'b0;
			nxt_node_tx_valid = 1'b0;
			nxt_ans_q = 1'b0;
			tx_we = 1'b0;
			rx_we = 1'b0;
		end
	end

	// ==========================================================
	// Registers; power-up leaves LAM generation off
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_RESTART;
			tmr_ff <= TMR_ZERO;
			tx_wp_ff <= PTR_ZERO;
			tx_rp_ff <= PTR_ZERO;
			tx_cnt_ff <= CNT_ZERO;
			rx_wp_ff <= PTR_ZERO;
			rx_rp_ff <= PTR_ZERO;
			rx_cnt_ff <= CNT_ZERO;
			tx_gap_ff <= 1'b0;
			hdr_bad_ff <= 1'b0;
			flush_ff <= 1'b0;
			err_word_ff <= WORD_ZERO;
			rd_en_ff <= 1'b0;
			lam_en_ff <= 1'b0;
			lam_ff <= 1'b0;
			ans_valid_ff <= 1'b0;
			ans_x_ff <= 1'b0;
			ans_q_ff <= 1'b0;
			rd_data_ff <= WORD_ZERO;
			node_active_ff <= 1'b0;
			node_tx_valid_ff <= 1'b0;
			node_tx_data_ff <= WORD_ZERO;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			tx_wp_ff <= nxt_tx_wp;
			tx_rp_ff <= nxt_tx_rp;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_wp_ff <= nxt_rx_wp;
			rx_rp_ff <= nxt_rx_rp;
			rx_cnt_ff <= nxt_rx_cnt;
			tx_gap_ff <= nxt_tx_gap;
			hdr_bad_ff <= nxt_hdr_bad;
			flush_ff <= nxt_flush;
			err_word_ff <= nxt_err_word;
			rd_en_ff <= nxt_rd_en;
			lam_en_ff <= nxt_lam_en;
			lam_ff <= nxt_lam;
			ans_valid_ff <= nxt_ans_valid;
			ans_x_ff <= nxt_ans_x;
			ans_q_ff <= nxt_ans_q;
			rd_data_ff <= nxt_rd_data;
			node_active_ff <= nxt_node_active;
			node_tx_valid_ff <= nxt_node_tx_valid;
			node_tx_data_ff <= nxt_node_tx_data;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	logic reset_src;
	assign reset_src = dataway_c || dataway_z || panel_reset;

	sequence s_err_store;
		(state_ff == ST_ERR) ##1 (state_ff == ST_IDLE && rd_en_ff && rx_cnt_ff != CNT_ZERO);
	endsequence

	sequence s_fn_strobe(logic [4:0] fn);
		cmd_strobe && cmd_func == fn && state_ff != ST_RESTART && !reset_src;
	endsequence

	restart_entry_a: assert property ((reset_src || (cmd_strobe && cmd_func == FN_RESET)) |=>
		(state_ff == ST_RESTART && tmr_ff == TMR_ZERO))
		else $error("reset source did not enter restart");
	restart_clean_a: assert property ((state_ff == ST_RESTART) |->
		(!lam_ff && !lam_en_ff && tx_cnt_ff == CNT_ZERO && !node_tx_valid_ff))
		else $error("restart state not clean");
	restart_refuse_a: assert property ((cmd_strobe && state_ff == ST_RESTART) |=>
		(ans_valid_ff && !ans_q_ff && $stable(rx_cnt_ff)))
		else $error("command accepted during restart");
	tx_push_a: assert property (s_fn_strobe(FN_WRITE) and (idle && tx_cnt_ff != FIFO_FULL_CNT)
		|=> (ans_q_ff && tx_cnt_ff == $past(tx_cnt_ff) + CNT_ONE))
		else $error("transmit word not stored");
	tx_refuse_a: assert property ((cmd_strobe && cmd_func == FN_WRITE && !reset_src &&
		(!idle || tx_cnt_ff == FIFO_FULL_CNT)) |=> (!ans_q_ff && $stable(tx_wp_ff)))
		else $error("transmit write not refused");
	start_send_a: assert property (s_fn_strobe(FN_START) and (idle && tx_cnt_ff != CNT_ZERO)
		|=> (state_ff == ST_TX && ans_q_ff) ##1 node_tx_valid_ff)
		else $error("start did not send");
	empty_error_a: assert property (s_fn_strobe(FN_START) and (idle && tx_cnt_ff == CNT_ZERO)
		|=> (err_word_ff == ERR_NO_DATA) and s_err_store)
		else $error("empty start did not store error");
	start_busy_a: assert property (s_fn_strobe(FN_START) and !idle |=> !ans_q_ff)
		else $error("start accepted while busy");
	slave_timeout_a: assert property ((state_ff == ST_WAIT && tmr_ff == TIMEOUT_LAST &&
		!node_rx_valid && !rst_req) |=> (err_word_ff == ERR_NO_SLAVE) and s_err_store)
		else $error("timeout word not stored");
	lam_raise_a: assert property ((state_ff == ST_ERR && !rst_req) |=>
		(lam_ff == $past(lam_en_ff)))
		else $error("lam not raised with data");
	lam_clear_a: assert property (s_fn_strobe(FN_READ) and (rd_en_ff && rx_cnt_ff == CNT_ONE)
		|=> (!lam_ff && ans_q_ff) ##2 (!lam_ff || !rd_en_ff || rx_cnt_ff != CNT_ZERO))
		else $error("lam kept after last word");
	lam_test_a: assert property (s_fn_strobe(FN_TEST_LAM) |=> (ans_q_ff == $past(lam_ff)))
		else $error("lam test answer wrong");
	lam_enable_a: assert property (s_fn_strobe(FN_LAM_ON) |=> (lam_en_ff && ans_x_ff))
		else $error("lam enable not set");

endmodule : cnm_ctrl

/* sim/cnm_node_model.sv */
// Purpose: Behavioural network node and slave that answer the controller's transmit stream
// Assumes: One reply per packet; a packet ends after 8 quiet cycles on the transmit side
// Notes: Reply is a header word, then the count of words received, flagged last
`timescale 1ns/100ps
module cnm_node_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic reply_en,
	input wire logic [15:0] reply_hdr,
	input wire logic tx_valid,
	input wire logic [15:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [15:0] rx_data,
	output logic rx_last
);
	logic [15:0] got;
	logic [3:0] quiet;
	logic [1:0] ph;
	logic send2;

	// ==========================================================
	// Transmit sink and reply source
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			got <= 16'h0000;
			quiet <= 4'h0;
			ph <= 2'h0;
			send2 <= 1'b0;
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 16'h0000;
			rx_last <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			// Slow mode stalls three cycles in four
			tx_ready <= !slow || ph == 2'h0;
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			// Idle data toggles so stale words cannot pass for fresh ones
			rx_data <= ~rx_data;
			if (tx_valid && tx_ready) begin
				got <= got + 16'h0001;
				quiet <= 4'h0;
			end else if (got != 16'h0000 && quiet != 4'h8) begin
				quiet <= quiet + 4'h1;
			end
			if (send2) begin
				rx_valid <= 1'b1;
				rx_data <= got;
				rx_last <= 1'b1;
				got <= 16'h0000;
				send2 <= 1'b0;
			end else if (got != 16'h0000 && quiet == 4'h8) begin
				// Missing slave: forget the packet and stay silent
				if (reply_en) begin
					rx_valid <= 1'b1;
					rx_data <= reply_hdr;
					send2 <= 1'b1;
				end else begin
					got <= 16'h0000;
				end
			end
		end
	end
endmodule : cnm_node_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the crate network master controller
// Assumes: Short restart and timeout counts; commands issued on falling edges
// Notes: Words handed to the node are logged and compared with what was written
`timescale 1ns/100ps
module tb_top;
	import cnm_pkg::*;
	localparam int unsigned RC = 20;
	localparam int unsigned TC = 50;
	logic mclk, arst_n, stb, dc, dz, pb, av, ax, aq, lam, act, tv, tr, rv, rl, slow, ren;
	logic cx, cq;
	logic [4:0] fn;
	logic [15:0] wd, rd, td, rxd, hdr, cd;
	int fails, checks;
	logic [15:0] sent[$];
	logic [15:0] seen[$];

	cnm_ctrl #(.RESTART_CYC(RC), .TIMEOUT_CYC(TC)) DUT (.mclk(mclk), .arst_n(arst_n),
		.cmd_strobe(stb), .cmd_func(fn), .cmd_wdata(wd), .dataway_c(dc), .dataway_z(dz),
		.panel_reset(pb), .ans_valid_ff(av), .ans_x_ff(ax), .ans_q_ff(aq), .rd_data_ff(rd),
		.lam_ff(lam), .node_active_ff(act), .node_tx_valid_ff(tv), .node_tx_data_ff(td),
		.node_tx_ready(tr), .node_rx_valid(rv), .node_rx_data(rxd), .node_rx_last(rl));
	cnm_node_model node (.mclk(mclk), .arst_n(arst_n), .slow(slow), .reply_en(ren),
		.reply_hdr(hdr), .tx_valid(tv), .tx_data(td), .tx_ready(tr), .rx_valid(rv),
		.rx_data(rxd), .rx_last(rl));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Log every word the node accepts
	always @(posedge mclk) begin
		if (tv === 1'b1 && tr === 1'b1) begin
			seen.push_back(td);
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk

	// One strobe, then a bounded wait for the answer pulse
	task automatic cmd(input logic [4:0] f, input logic [15:0] w);
		int n;
		@(negedge mclk);
		stb = 1'b1;
		fn = f;
		wd = w;
		@(negedge mclk);
		stb = 1'b0;
		n = 0;
		while (av !== 1'b1 && n < 3) begin
			@(negedge mclk);
			n++;
		end
		chk(av === 1'b1, "no answer pulse");
		cx = ax;
		cq = aq;
		cd = rd;
	endtask : cmd

	task automatic expq(input logic [4:0] f, input logic [15:0] w, input logic q, input string m);
		cmd(f, w);
		chk(cx === 1'b1 && cq === q, m);
	endtask : expq

	task automatic rdw(input logic [15:0] e);
		cmd(FN_READ, 16'h0000);
		chk(cq === 1'b1 && cd === e, "read word mismatch");
	endtask : rdw

	task automatic poll();
		int n;
		n = 0;
		cq = 1'b0;
		while (cq !== 1'b1 && n < 200) begin
			cmd(FN_READ, 16'h0000);
			n++;
		end
		chk(cq === 1'b1, "polling found no data");
	endtask : poll

	task automatic settle();
		repeat (RC + 4) @(negedge mclk);
	endtask : settle

	// ==========================================================
	// Scenarios
	task automatic t_power();
		expq(FN_TEST_LAM, 16'h0000, 1'b0, "answer during restart");
		settle();
		expq(FN_TEST_LAM, 16'h0000, 1'b0, "lam after power up");
		cmd(5'h01, 16'h0000);
		chk(cx === 1'b0 && cq === 1'b0, "unsupported code answered");
	endtask : t_power

	task automatic t_empty(input logic le);
		expq(le ? FN_LAM_ON : FN_LAM_OFF, 16'h0000, 1'b1, "lam enable change");
		expq(FN_START, 16'h0000, 1'b1, "empty start");
		repeat (3) @(negedge mclk);
		chk(lam === le, "lam after error word");
		expq(FN_TEST_LAM, 16'h0000, le, "lam test");
		rdw(ERR_NO_DATA);
		chk(lam === 1'b0, "lam after last read");
		expq(FN_READ, 16'h0000, 1'b0, "buffer drained");
	endtask : t_empty

	task automatic t_good(input logic [15:0] h);
		ren = 1'b1;
		hdr = h;
		slow = 1'b1;
		sent.delete();
		seen.delete();
		for (int i = 0; i < 3; i++) begin
			sent.push_back(16'h0a50 + 16'(i));
			expq(FN_WRITE, sent[i], 1'b1, "write accepted");
		end
		expq(FN_START, 16'h0000, 1'b1, "start accepted");
		chk(act === 1'b1, "node not busy after start");
		expq(FN_WRITE, 16'h0bad, 1'b0, "write while busy");
		expq(FN_START, 16'h0000, 1'b0, "start while busy");
		poll();
		chk(cd === h, "reply header");
		rdw(16'h0003);
		expq(FN_READ, 16'h0000, 1'b0, "reply finished");
		chk(act === 1'b0, "node busy after reply");
		chk(seen.size() == 3, "word count sent");
		foreach (sent[i]) chk(seen[i] === sent[i], "send order");
	endtask : t_good

	task automatic t_bad();
		ren = 1'b1;
		hdr = 16'h1234;
		slow = 1'b0;
		expq(FN_WRITE, 16'h0001, 1'b1, "write accepted");
		expq(FN_START, 16'h0000, 1'b1, "start accepted");
		poll();
		chk(cd === ERR_BAD_ID, "bad header word");
		expq(FN_READ, 16'h0000, 1'b0, "reply flushed");
	endtask : t_bad

	task automatic t_timeout();
		int n;
		ren = 1'b0;
		expq(FN_LAM_ON, 16'h0000, 1'b1, "lam enable");
		expq(FN_WRITE, 16'h0002, 1'b1, "write accepted");
		expq(FN_START, 16'h0000, 1'b1, "start accepted");
		expq(FN_READ, 16'h0000, 1'b0, "no data while waiting");
		n = 0;
		while (lam !== 1'b1 && n < TC + 100) begin
			@(negedge mclk);
			n++;
		end
		chk(lam === 1'b1 && n >= TC, "lam after slave timeout");
		rdw(ERR_NO_SLAVE);
		chk(lam === 1'b0, "lam after last read");
		expq(FN_LAM_OFF, 16'h0000, 1'b1, "lam disable");
	endtask : t_timeout

	task automatic t_full();
		for (int i = 0; i < 256; i++) begin
			expq(FN_WRITE, 16'(i), 1'b1, "fill transmit buffer");
		end
		expq(FN_WRITE, 16'hffff, 1'b0, "write when full");
		expq(FN_LAM_ON, 16'h0000, 1'b1, "lam enable");
		expq(FN_RESET, 16'h0000, 1'b0, "reset function");
		expq(FN_WRITE, 16'h0001, 1'b0, "refused in restart");
		settle();
		expq(FN_START, 16'h0000, 1'b1, "start after reset");
		repeat (3) @(negedge mclk);
		chk(lam === 1'b0, "lam disabled by reset");
		rdw(ERR_NO_DATA);
	endtask : t_full

	// Each reset line aborts a transfer in flight
	task automatic t_lines();
		ren = 1'b1;
		hdr = 16'h0000;
		for (int k = 0; k < 3; k++) begin
			expq(FN_WRITE, 16'h0003, 1'b1, "write accepted");
			expq(FN_START, 16'h0000, 1'b1, "start accepted");
			@(negedge mclk);
			dc = (k == 0);
			dz = (k == 1);
			pb = (k == 2);
			@(negedge mclk);
			dc = 1'b0;
			dz = 1'b0;
			pb = 1'b0;
			expq(FN_START, 16'h0000, 1'b0, "refused after reset line");
			settle();
		end
		expq(FN_START, 16'h0000, 1'b1, "start after abort");
		rdw(ERR_NO_DATA);
		expq(FN_READ, 16'h0000, 1'b0, "no stale reply");
	endtask : t_lines

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{arst_n, stb, dc, dz, pb, slow, ren} = 7'h00;
		fn = 5'h00;
		wd = 16'h0000;
		hdr = 16'h0000;
		fails = 0;
		checks = 0;
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		t_power();
		t_empty(1'b1);
		t_empty(1'b0);
		t_good(HDR_SUCCESS);
		t_good(16'hff12);
		t_bad();
		t_timeout();
		t_full();
		t_lines();
		report_and_stop();
	end

	initial begin
		#(8 * 40000);
		fails++;
		report_and_stop();
	end
endmodule : tb_top
